//--- logic/status_lamp_pattern_driver.sv
// Behaviour
// - Both lamps are off when logic power is missing or the module failed.
// - During auto-addressing the run lamp flickers and the fault lamp is off.
// - Watchdog expiry holds both lamps steadily on.
// - Powered, tested and operational gives run lamp on, fault lamp off.
// - Input over-voltage keeps the run lamp on and flickers the fault lamp.
// - Missing field power or a distributor short flickers the fault lamp.
// - Pre-operational mode drives the run lamp with single blink.
// - A nonfatal error drives the fault lamp with single blink.
// - A stopped island bus drives the fault lamp with double blink.
// - Flicker repeats 50 ms lit then 50 ms dark.
// - Single blink repeats 200 ms lit then 200 ms dark.
// - Double blink lights 200 ms, darkens 200 ms, lights again, darkens 200 ms, then repeats.
// - Distributor faults may be reported up to 15 ms after the event.
// - Field power faults local to the module are flagged one clock cycle later, through the output register.
// - Each of eight channel readings is a signed 15-bit magnitude plus sign.
`default_nettype none
module status_lamp_pattern_driver #(
  parameter int unsigned TICK_CYCLES = lamp_pkg::TICK_CYCLES,
  parameter int unsigned FIELD_DELAY_MS = lamp_pkg::FIELD_DELAY_MS
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  // Module conditions, same clock domain
  input wire logic logic_power_ok_i,
  input wire logic module_failed_i,
  input wire logic auto_addressing_i,
  input wire logic watchdog_expired_i,
  input wire logic self_test_passed_i,
  input wire logic operational_i,
  input wire logic over_voltage_i,
  input wire logic pre_operational_i,
  input wire logic nonfatal_error_i,
  input wire logic island_bus_running_i,
  // Field power faults
  input wire logic field_power_local_fault_i,
  input wire logic field_power_distributor_fault_i,
  // Channel readings
  input wire logic [lamp_pkg::CHANNELS*lamp_pkg::DATA_W-1:0] channel_raw_i,
  input wire logic channel_valid_i,
  output logic [lamp_pkg::CHANNELS*lamp_pkg::DATA_W-1:0] channel_data_o,
  // Lamps and field fault flag
  output logic run_state_lamp_o,
  output logic fault_lamp_o,
  output logic field_fault_o
);
  localparam int unsigned FLICK_W = $clog2(lamp_pkg::FLICKER_MS + 1);
  localparam int unsigned BLINK_W = $clog2(lamp_pkg::BLINK_MS + 1);
  localparam int unsigned DLY_W = $clog2(FIELD_DELAY_MS + 2);
  localparam logic [FLICK_W-1:0] FLICK_LAST = FLICK_W'(lamp_pkg::FLICKER_MS - 1);
  localparam logic [BLINK_W-1:0] BLINK_LAST = BLINK_W'(lamp_pkg::BLINK_MS - 1);
  localparam logic [DLY_W-1:0] DLY_LAST = DLY_W'(FIELD_DELAY_MS);

  wire logic tick;

  // Millisecond timebase
  ms_timebase #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_timebase (
    .sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .tick_o(tick)
  );

  // Phase counters and phase bits
  logic [FLICK_W-1:0] flick_cnt_reg;
  logic [BLINK_W-1:0] blink_cnt_reg;
  logic flick_dark_reg;
  logic blink_dark_reg;
  logic [1:0] slot_reg;

  wire logic flick_wrap = tick && (flick_cnt_reg == FLICK_LAST);
  wire logic blink_wrap = tick && (blink_cnt_reg == BLINK_LAST);
  wire logic [FLICK_W-1:0] flick_cnt_next =
    flick_wrap ? '0 : (tick ? flick_cnt_reg + FLICK_W'(1) : flick_cnt_reg);
  wire logic [BLINK_W-1:0] blink_cnt_next =
    blink_wrap ? '0 : (tick ? blink_cnt_reg + BLINK_W'(1) : blink_cnt_reg);
  wire logic [1:0] slot_next = blink_wrap ? slot_reg + 2'h1 : slot_reg;

  // Pattern timing counters, lit phase after reset
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      flick_cnt_reg <= '0;
      blink_cnt_reg <= '0;
      flick_dark_reg <= 1'b0;
      blink_dark_reg <= 1'b0;
      slot_reg <= 2'h0;
    end
    else
    begin
      flick_cnt_reg <= flick_cnt_next;
      blink_cnt_reg <= blink_cnt_next;
      flick_dark_reg <= flick_dark_reg ^ flick_wrap;
      blink_dark_reg <= blink_dark_reg ^ blink_wrap;
      slot_reg <= slot_next;
    end
  end

  // Waveforms for each pattern
  wire logic wave_flicker = !flick_dark_reg;
  wire logic wave_single = !blink_dark_reg;
  wire logic wave_double = lamp_pkg::DOUBLE_MASK[slot_reg];

  // Distributor fault qualification, delayed by up to the allowed latency
  logic [1:0] dist_sync_reg;
  logic dist_fault_reg;
  logic [DLY_W-1:0] dly_cnt_reg;
  wire logic dist_seen = dist_sync_reg[1];
  wire logic dly_done = (dly_cnt_reg == DLY_LAST);
  wire logic [DLY_W-1:0] dly_cnt_next =
    !dist_seen ? '0 : ((tick && !dly_done) ? dly_cnt_reg + DLY_W'(1) : dly_cnt_reg);
  wire logic dist_fault_next = dist_seen && (dly_cnt_next != '0 || dist_fault_reg);

  // Synchroniser and report stage
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      dist_sync_reg <= 2'h0;
      dly_cnt_reg <= '0;
      dist_fault_reg <= 1'b0;
    end
    else
    begin
      dist_sync_reg <= {dist_sync_reg[0], field_power_distributor_fault_i};
      dly_cnt_reg <= dly_cnt_next;
      dist_fault_reg <= dist_fault_next;
    end
  end

  // Local field faults reported one cycle later, through the output register
  wire logic local_fault = field_power_local_fault_i;
  wire logic field_fault = local_fault || dist_fault_reg;

  // Condition decode
  wire logic dead = !logic_power_ok_i || module_failed_i;
  wire logic healthy = self_test_passed_i && operational_i;

  // Run lamp pattern selection
  lamp_pkg::pattern_t run_pat;
  always_comb
  begin
    if (dead)
      run_pat = lamp_pkg::PAT_OFF;
    else if (watchdog_expired_i)
      run_pat = lamp_pkg::PAT_ON;
    else if (auto_addressing_i)
      run_pat = lamp_pkg::PAT_FLICKER;
    else if (pre_operational_i)
      run_pat = lamp_pkg::PAT_SINGLE;
    else if (over_voltage_i || healthy)
      run_pat = lamp_pkg::PAT_ON;
    else
      run_pat = lamp_pkg::PAT_OFF;
  end

  // Fault lamp pattern selection
  lamp_pkg::pattern_t fault_pat;
  always_comb
  begin
    if (dead)
      fault_pat = lamp_pkg::PAT_OFF;
    else if (watchdog_expired_i)
      fault_pat = lamp_pkg::PAT_ON;
    else if (auto_addressing_i)
      fault_pat = lamp_pkg::PAT_OFF;
    else if (over_voltage_i || field_fault)
      fault_pat = lamp_pkg::PAT_FLICKER;
    else if (!island_bus_running_i)
      fault_pat = lamp_pkg::PAT_DOUBLE;
    else if (nonfatal_error_i)
      fault_pat = lamp_pkg::PAT_SINGLE;
    else
      fault_pat = lamp_pkg::PAT_OFF;
  end

  // Pattern to lamp level
  function automatic logic pat_level(input lamp_pkg::pattern_t p, input logic fl, input logic sb,
                                     input logic db);
    logic v;
    v = 1'b0;
    case (p)
      lamp_pkg::PAT_ON: v = 1'b1;
      lamp_pkg::PAT_FLICKER: v = fl;
      lamp_pkg::PAT_SINGLE: v = sb;
      lamp_pkg::PAT_DOUBLE: v = db;
      default: v = 1'b0;
    endcase
    return v;
  endfunction

  wire logic run_lamp_next = pat_level(run_pat, wave_flicker, wave_single, wave_double);
  wire logic fault_lamp_next = pat_level(fault_pat, wave_flicker, wave_single, wave_double);

  // Lamp output registers
  logic run_lamp_reg;
  logic fault_lamp_reg;
  logic field_fault_reg;
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      run_lamp_reg <= 1'b0;
      fault_lamp_reg <= 1'b0;
      field_fault_reg <= 1'b0;
    end
    else
    begin
      run_lamp_reg <= run_lamp_next;
      fault_lamp_reg <= fault_lamp_next;
      field_fault_reg <= field_fault;
    end
  end

  assign run_state_lamp_o = run_lamp_reg;
  assign fault_lamp_o = fault_lamp_reg;
  assign field_fault_o = field_fault_reg;

  // Channel data: signed, sign bit above the magnitude
  logic [lamp_pkg::CHANNELS*lamp_pkg::DATA_W-1:0] chan_reg;
  genvar g;
  generate
    for (g = 0; g < lamp_pkg::CHANNELS; g++)
    begin : g_chan
      wire logic [lamp_pkg::DATA_W-1:0] raw =
        channel_raw_i[g*lamp_pkg::DATA_W +: lamp_pkg::DATA_W];
      always_ff @(posedge sys_clk_i or negedge arst_n_i)
      begin
        if (!arst_n_i)
          chan_reg[g*lamp_pkg::DATA_W +: lamp_pkg::DATA_W] <= '0;
        else if (channel_valid_i)
          chan_reg[g*lamp_pkg::DATA_W +: lamp_pkg::DATA_W] <=
            {raw[lamp_pkg::MAG_W], raw[lamp_pkg::MAG_W-1:0]};
      end
    end
  endgenerate

  assign channel_data_o = chan_reg;
endmodule
`default_nettype wire

//--- logic/lamp_pkg.sv
`default_nettype none
package lamp_pkg;
  // Timebase and pattern timing
  localparam int unsigned CLK_HZ = 250000000;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned FLICKER_MS = 50;
  localparam int unsigned BLINK_MS = 200;
  localparam int unsigned FIELD_DELAY_MS = 15;
  // Channel data format
  localparam int unsigned CHANNELS = 8;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned MAG_W = 15;
  // Double-blink frame in 200 ms slots: lit, dark, lit, then dark gap
  localparam logic [3:0] DOUBLE_MASK = 4'h5;
  localparam int unsigned DOUBLE_SLOTS = 4;
  // Lamp pattern selection
  typedef enum logic [2:0] {
    PAT_OFF,
    PAT_ON,
    PAT_FLICKER,
    PAT_SINGLE,
    PAT_DOUBLE
  } pattern_t;
endpackage
`default_nettype wire

//--- logic/ms_timebase.sv
`default_nettype none
// Free-running one-millisecond tick from the system clock
module ms_timebase #(
  parameter int unsigned TICK_CYCLES = lamp_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  // Tick
  output logic tick_o
);
  localparam int unsigned CW = $clog2(TICK_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);
  logic [CW-1:0] cnt_reg;
  wire logic at_last = (cnt_reg == LAST);
  wire logic [CW-1:0] cnt_next = at_last ? '0 : cnt_reg + CW'(1);

  // Cycle counter
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      cnt_reg <= '0;
    else
      cnt_reg <= cnt_next;
  end

  assign tick_o = at_last;
endmodule
`default_nettype wire

//--- tb/status_lamp_chk.sv
`default_nettype none
// Port-level relations of the lamp driver
module status_lamp_chk (
  // Clock and reset
  input wire logic sys_clk_i, arst_n_i,
  // Conditions and channel input
  input wire logic logic_power_ok_i, module_failed_i, auto_addressing_i, watchdog_expired_i,
  input wire logic self_test_passed_i, operational_i, over_voltage_i, pre_operational_i,
  input wire logic field_power_local_fault_i, field_power_distributor_fault_i,
  input wire logic [127:0] channel_raw_i,
  input wire logic channel_valid_i,
  // Outputs under watch
  input wire logic [127:0] channel_data_o,
  input wire logic run_state_lamp_o, fault_lamp_o, field_fault_o
);
  // Working module, then free of overriding states
  wire logic alive = logic_power_ok_i & ~module_failed_i;
  wire logic calm = alive & ~watchdog_expired_i & ~auto_addressing_i;
  default clocking @(posedge sys_clk_i);
  endclocking
  default disable iff (!arst_n_i);
  // Lamp, fault flag and channel relations
  dead_dark_a: assert property (!alive |=> !run_state_lamp_o && !fault_lamp_o)
    else $error("lamp lit while dead");
  wdog_on_a: assert property (alive && watchdog_expired_i |=>
    run_state_lamp_o && fault_lamp_o) else $error("watchdog lamps wrong");
  addr_dark_a: assert property (alive && !watchdog_expired_i && auto_addressing_i |=>
    !fault_lamp_o) else $error("fault lit in addressing");
  well_run_a: assert property (calm && self_test_passed_i && operational_i &&
    !pre_operational_i |=> run_state_lamp_o) else $error("run dark while healthy");
  ov_run_a: assert property (calm && over_voltage_i && !pre_operational_i |=>
    run_state_lamp_o) else $error("run dark on over-voltage");
  local_flag_a: assert property (field_power_local_fault_i |=> field_fault_o)
    else $error("local fault not flagged");
  dist_clear_a: assert property (
    (!field_power_local_fault_i && !field_power_distributor_fault_i) [*5] |=> !field_fault_o)
    else $error("stale field fault");
  chan_load_a: assert property (channel_valid_i |=>
    channel_data_o == $past(channel_raw_i)) else $error("channel not loaded");
  // Main scenarios
  cover property (calm && over_voltage_i);
  cover property (alive && watchdog_expired_i);
  cover property ($rose(field_fault_o));
endmodule
`default_nettype wire

//--- tb/lamp_observer.sv
`default_nettype none
// Operator view of one lamp: length of the last lit and dark stretch
module lamp_observer (
  input wire logic sys_clk_i, arst_n_i, lamp_i,
  output logic [15:0] lit_len_o, dark_len_o
);
  logic [15:0] run_len_reg;
  logic last_reg;
  // Close a stretch whenever the lamp changes
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      run_len_reg <= 16'h0000;
      last_reg <= 1'b0;
      lit_len_o <= 16'h0000;
      dark_len_o <= 16'h0000;
    end
    else if (lamp_i != last_reg)
    begin
      if (last_reg)
        lit_len_o <= run_len_reg;
      else
        dark_len_o <= run_len_reg;
      run_len_reg <= 16'h0001;
      last_reg <= lamp_i;
    end
    else
      run_len_reg <= run_len_reg + 16'h0001;
  end
endmodule
`default_nettype wire

//--- tb/test_status_lamp_pattern_driver.sv
`default_nettype none
module test_status_lamp_pattern_driver;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int FL = lamp_pkg::FLICKER_MS * 10;
  localparam int BL = lamp_pkg::BLINK_MS * 10;
  localparam logic [11:0] H = 12'h231;
  localparam logic [127:0] P = 128'h8000_7fff_ffff_0001_8001_7ffe_0000_1234;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic vld = 1'b0;
  logic [11:0] c = 12'h000;
  logic [127:0] raw = 128'h0;
  wire logic [127:0] dat;
  wire logic rl, fl, ff;
  wire logic [15:0] rlit, rdark, flit, fdark;
  int mismatches = 0;
  int n_compared = 0;
  // Clock
  always #2 sys_clk = ~sys_clk;
  // Block with short timing counts, and one operator per lamp
  status_lamp_pattern_driver #(.TICK_CYCLES(10), .FIELD_DELAY_MS(2)) dut (
    .sys_clk_i(sys_clk), .arst_n_i(rst_n), .logic_power_ok_i(c[0]), .module_failed_i(c[1]),
    .auto_addressing_i(c[2]), .watchdog_expired_i(c[3]), .self_test_passed_i(c[4]),
    .operational_i(c[5]), .over_voltage_i(c[6]), .pre_operational_i(c[7]),
    .nonfatal_error_i(c[8]), .island_bus_running_i(c[9]), .field_power_local_fault_i(c[10]),
    .field_power_distributor_fault_i(c[11]), .channel_raw_i(raw), .channel_valid_i(vld),
    .channel_data_o(dat), .run_state_lamp_o(rl), .fault_lamp_o(fl), .field_fault_o(ff));
  lamp_observer run_obs (.sys_clk_i(sys_clk), .arst_n_i(rst_n), .lamp_i(rl),
    .lit_len_o(rlit), .dark_len_o(rdark));
  lamp_observer flt_obs (.sys_clk_i(sys_clk), .arst_n_i(rst_n), .lamp_i(fl),
    .lit_len_o(flit), .dark_len_o(fdark));
  task automatic chk(input logic [127:0] g, input logic [127:0] e);
    n_compared++;
    if (g !== e)
    begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Set conditions just after an edge, then let n edges pass
  task automatic put(input logic [11:0] v, input int n);
    @(posedge sys_clk);
    #1 c = v;
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic t_levels;
    put(H & ~12'h001, 2);
    chk({rl, fl}, 2'b00);
    put(H | 12'h002, 2);
    chk({rl, fl}, 2'b00);
    put(H | 12'h00c, 2);
    chk({rl, fl}, 2'b11);
    put(H, 2);
    chk({rl, fl}, 2'b10);
    $display("steady levels done");
  endtask
  task automatic t_flicker;
    put(12'h005, 6 * FL);
    chk(fl, 1'b0);
    chk({rlit, rdark}, {16'(FL), 16'(FL)});
    put(H | 12'h040, 6 * FL);
    chk(rl, 1'b1);
    chk({flit, fdark}, {16'(FL), 16'(FL)});
    $display("flicker done");
  endtask
  task automatic t_blink;
    put(H | 12'h180, 6 * BL);
    chk({rlit, rdark}, {16'(BL), 16'(BL)});
    chk({flit, fdark}, {16'(BL), 16'(BL)});
    put(12'h131, 10 * BL);
    chk({flit, fdark}, {16'(BL), 16'(BL)});
    put(12'h531, 6 * FL);
    chk({flit, fdark}, {16'(FL), 16'(FL)});
    $display("blink done");
  endtask
  task automatic t_field;
    put(H | 12'h400, 1);
    chk(ff, 1'b1);
    put(H, 8);
    put(H | 12'h800, 44);
    chk(ff, 1'b1);
    put(H, 8);
    chk(ff, 1'b0);
    raw = P;
    vld = 1'b1;
    @(posedge sys_clk);
    #1 vld = 1'b0;
    raw = ~P;
    chk(dat, P);
    @(posedge sys_clk);
    #1 chk(dat, P);
    $display("field and channel done");
  endtask
  task automatic t_rst;
    c = H | 12'h080;
    rst_n = 1'b0;
    @(posedge sys_clk);
    #1 rst_n = 1'b1;
    put(c, 1);
    chk(rl, 1'b1);
    repeat (BL - 100) @(posedge sys_clk);
    #1 chk(rl, 1'b1);
    repeat (200) @(posedge sys_clk);
    #1 chk(rl, 1'b0);
    $display("reset restart done");
  endtask
  // Main sequence
  initial
  begin
    repeat (2) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    t_levels;
    t_flicker;
    t_blink;
    t_field;
    t_rst;
    finish_test;
  end
  // Watchdog
  initial
  begin
    #300us;
    mismatches++;
    finish_test;
  end
endmodule
bind status_lamp_pattern_driver status_lamp_chk watch (.*);
`default_nettype wire
